// ### hw/gdic_cfg.svh
// constants for the gate driver input controller: offsets, fields, reset values, timing counts
// assumes a 200 MHz pclk and an APB master with 32-bit data
// Function
// - The controller never leaves a PWM input or the reset/enable input floating and grounds the unused inverting input.
// - The driver is enabled only while reset/enable is high, and the controller drives that level to enable or disable.
// - The controller sends its clear pulse only after the fault mute interval has passed since the fault latched.
// - The controller may feed the non-inverting PWM signal to reset/enable so the driver is reset every cycle.
// - With the inverting PWM input, the per-cycle reset signal is the inverse of the PWM fed to that input.
`ifndef GDIC_CFG_SVH
`define GDIC_CFG_SVH

// register offsets (byte addresses)
`define GDIC_OFS_CTRL 12'h000
`define GDIC_OFS_PERIOD 12'h004
`define GDIC_OFS_DUTY 12'h008
`define GDIC_OFS_CMD 12'h00C
`define GDIC_OFS_STATUS 12'h010

// control fields
`define GDIC_CTRL_ENABLE 0
`define GDIC_CTRL_AUTO 1
`define GDIC_CTRL_INV 2
`define GDIC_CTRL_RUN 3
`define GDIC_CTRL_RST 4'h0

// command and status fields
`define GDIC_CMD_CLEAR 0
`define GDIC_ST_FAULT 0
`define GDIC_ST_STICKY 1
`define GDIC_ST_SUPPLY 2
`define GDIC_ST_BUSY 3
`define GDIC_ST_MUTED 4

`define GDIC_PERIOD_RST 16'h0FA0
`define GDIC_DUTY_RST 16'h07D0

// timing
`define GDIC_CLK_MHZ 200
`define GDIC_MIN_PULSE_NS 40
`define GDIC_MUTE_NS 2000
`define GDIC_FILTER_NS 1000
`define GDIC_MIN_PULSE_CYC (((`GDIC_MIN_PULSE_NS * `GDIC_CLK_MHZ) + 999) / 1000)
`define GDIC_MUTE_CYC (((`GDIC_MUTE_NS * `GDIC_CLK_MHZ) + 999) / 1000)
// one cycle beyond the filter so the low level lasts strictly longer than it
`define GDIC_HOLD_CYC ((((`GDIC_FILTER_NS * `GDIC_CLK_MHZ) + 999) / 1000) + 1)

`endif

// ### hw/gdic_pkg.sv
// types shared by the gate driver input controller
// assumes gdic_cfg.svh for all numeric constants
package gdic_pkg;

  typedef logic [15:0] gdic_cnt_t;

  typedef enum logic [1:0] {
    GDIC_IDLE,
    GDIC_MUTE,
    GDIC_ARMED,
    GDIC_HOLD
  } gdic_clr_state_e;

endpackage : gdic_pkg

// ### hw/gdic_pwm_gen.sv
// pwm generator with minimum high and low pulse widths
// assumes period and duty are in pclk cycles and stable while run is high
`timescale 1ns/1ps
`include "gdic_cfg.svh"
module gdic_pwm_gen import gdic_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic run,
  input wire gdic_cnt_t period,
  input wire gdic_cnt_t duty,
  // output
  output logic pwm_q
);

  localparam gdic_cnt_t MIN_W = 16'(`GDIC_MIN_PULSE_CYC);

  gdic_cnt_t cnt_q;
  gdic_cnt_t cnt_d;
  gdic_cnt_t hi_w;
  logic pwm_d;

  always_comb begin
    cnt_d = 16'h0000;
    if (run && (cnt_q < period - 16'h0001)) begin
      cnt_d = cnt_q + 16'h0001;
    end
    // width clamps keep edge pairs at least the minimum pulse width (GDIC_MIN_PULSE_CYC) apart, except the first high pulse after run rises, one cycle shorter
    hi_w = duty;
    if (duty < MIN_W) begin
      hi_w = MIN_W;
    end else if (duty > period - MIN_W) begin
      hi_w = period - MIN_W;
    end
    if (!run || duty == 16'h0000 || period < (MIN_W << 1)) begin
      pwm_d = 1'b0;
    end else if (duty >= period) begin
      pwm_d = 1'b1;
    end else begin
      pwm_d = (cnt_d < hi_w);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
      pwm_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      pwm_q <= pwm_d;
    end
  end

endmodule : gdic_pwm_gen

// ### hw/gdic_ctrl.sv
// controller for an isolated gate driver: drives both PWM inputs and reset/enable,
// watches the fault and supply-good lines, and runs the fault clear sequence
// assumes the driver's open-drain lines arrive pulled up and synchronous to pclk
`timescale 1ns/1ps
`include "gdic_cfg.svh"
module gdic_ctrl import gdic_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // driver pins
  output logic pwm_pos_out,
  output logic pwm_neg_out,
  output logic rst_en_out,
  input wire logic fault_report_out_n,
  input wire logic supply_good_in
);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [3:0] ctrl_q;
  logic [3:0] ctrl_d;
  gdic_cnt_t period_q;
  gdic_cnt_t period_d;
  gdic_cnt_t duty_q;
  gdic_cnt_t duty_d;
  logic sticky_q;
  logic sticky_d;
  logic clr_pend_q;
  logic clr_pend_d;
  logic fault_q;
  logic fault_prev_q;
  logic supply_q;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic hit;
  logic wr_acc;
  logic rd_setup;
  logic fault_rise;
  gdic_clr_state_e st_q;
  gdic_clr_state_e st_d;
  gdic_cnt_t tmr_q;
  gdic_cnt_t tmr_d;
  logic pwm_raw;
  logic pwm_on;
  logic pos_d;
  logic neg_d;
  logic rst_en_d;

  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign fault_rise = fault_q && !fault_prev_q;

  always_comb begin
    hit = 1'b1;
    if (paddr == `GDIC_OFS_CTRL) begin
      hit = 1'b1;
    end else if (paddr == `GDIC_OFS_PERIOD) begin
      hit = 1'b1;
    end else if (paddr == `GDIC_OFS_DUTY) begin
      hit = 1'b1;
    end else if (paddr == `GDIC_OFS_CMD) begin
      hit = 1'b1;
    end else if (paddr == `GDIC_OFS_STATUS) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end

  // zero-wait slave: answer in the access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = rdata_q;

  always_comb begin
    ctrl_d = ctrl_q;
    period_d = period_q;
    duty_d = duty_q;
    clr_pend_d = clr_pend_q;
    sticky_d = sticky_q;
    rdata_d = rdata_q;
    if (wr_acc && hit) begin
      if (paddr == `GDIC_OFS_CTRL) begin
        ctrl_d = pwdata[3:0];
      end else if (paddr == `GDIC_OFS_PERIOD) begin
        period_d = pwdata[15:0];
      end else if (paddr == `GDIC_OFS_DUTY) begin
        duty_d = pwdata[15:0];
      end else if (paddr == `GDIC_OFS_CMD) begin
        if (pwdata[`GDIC_CMD_CLEAR]) begin
          clr_pend_d = 1'b1;
        end
      end else if (paddr == `GDIC_OFS_STATUS) begin
        if (pwdata[`GDIC_ST_STICKY]) begin
          sticky_d = 1'b0;
        end
      end
    end
    // the pending clear is consumed when the low pulse starts
    if (st_q == GDIC_ARMED && clr_pend_q) begin
      clr_pend_d = 1'b0;
    end
    // a new fault beats a software clear of the sticky bit in the same cycle
    if (fault_q) begin
      sticky_d = 1'b1;
    end
    if (rd_setup) begin
      rdata_d = 32'h0000_0000;
      if (paddr == `GDIC_OFS_CTRL) begin
        rdata_d[3:0] = ctrl_q;
      end else if (paddr == `GDIC_OFS_PERIOD) begin
        rdata_d[15:0] = period_q;
      end else if (paddr == `GDIC_OFS_DUTY) begin
        rdata_d[15:0] = duty_q;
      end else if (paddr == `GDIC_OFS_STATUS) begin
        rdata_d[`GDIC_ST_FAULT] = fault_q;
        rdata_d[`GDIC_ST_STICKY] = sticky_q;
        rdata_d[`GDIC_ST_SUPPLY] = supply_q;
        rdata_d[`GDIC_ST_BUSY] = (st_q != GDIC_IDLE);
        rdata_d[`GDIC_ST_MUTED] = (st_q == GDIC_MUTE);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `GDIC_CTRL_RST;
      period_q <= `GDIC_PERIOD_RST;
      duty_q <= `GDIC_DUTY_RST;
      clr_pend_q <= 1'b0;
      sticky_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      fault_q <= 1'b0;
      fault_prev_q <= 1'b0;
      supply_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      period_q <= period_d;
      duty_q <= duty_d;
      clr_pend_q <= clr_pend_d;
      sticky_q <= sticky_d;
      rdata_q <= rdata_d;
      // open-drain lines: fault reads low when asserted, supply-good reads high when good; the pull-up gives high
      fault_q <= !fault_report_out_n;
      fault_prev_q <= fault_q;
      supply_q <= supply_good_in;
    end
  end

  // ----------------------------------------------------------------
  // fault clear sequence
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    tmr_d = tmr_q;
    if (tmr_q != 16'h0000) begin
      tmr_d = tmr_q - 16'h0001;
    end
    case (st_q)
      GDIC_IDLE: begin
        // in auto mode the pwm itself clears the driver every cycle
        if (fault_rise && !ctrl_q[`GDIC_CTRL_AUTO]) begin
          st_d = GDIC_MUTE;
          tmr_d = 16'(`GDIC_MUTE_CYC) - 16'h0001;
        end
      end
      GDIC_MUTE: begin
        // the driver would ignore a clear now, so none is sent
        if (tmr_q == 16'h0000) begin
          st_d = GDIC_ARMED;
        end
      end
      GDIC_ARMED: begin
        if (clr_pend_q) begin
          st_d = GDIC_HOLD;
          tmr_d = 16'(`GDIC_HOLD_CYC) - 16'h0001;
        end
      end
      GDIC_HOLD: begin
        if (tmr_q == 16'h0000) begin
          st_d = GDIC_IDLE;
        end
      end
      default: begin
        st_d = GDIC_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= GDIC_IDLE;
      tmr_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  gdic_pwm_gen u_pwm (
    .pclk(pclk),
    .presetn(presetn),
    .run(ctrl_q[`GDIC_CTRL_RUN]),
    .period(period_q),
    .duty(duty_q),
    .pwm_q(pwm_raw)
  );

  assign pwm_on = pwm_raw && ctrl_q[`GDIC_CTRL_ENABLE];

  always_comb begin
    // every pin is driven at all times, never left floating
    if (ctrl_q[`GDIC_CTRL_INV]) begin
      pos_d = 1'b1;
      neg_d = !pwm_on;
    end else begin
      pos_d = pwm_on;
      neg_d = 1'b0;
    end
    if (st_q == GDIC_HOLD) begin
      rst_en_d = 1'b0;
    end else if (ctrl_q[`GDIC_CTRL_AUTO]) begin
      // same level either way: inverting mode feeds the inverse of the neg input
      rst_en_d = ctrl_q[`GDIC_CTRL_INV] ? !neg_d : pos_d;
    end else begin
      rst_en_d = ctrl_q[`GDIC_CTRL_ENABLE];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_pos_out <= 1'b0;
      pwm_neg_out <= 1'b0;
      rst_en_out <= 1'b0;
    end else begin
      pwm_pos_out <= pos_d;
      pwm_neg_out <= neg_d;
      rst_en_out <= rst_en_d;
    end
  end

endmodule : gdic_ctrl

// ### sim/gdic_ctrl_chk.sv
// port checker for the gate driver controller
// assumes one pclk domain and the driver's fault line pulled up
`timescale 1ns/1ps
module gdic_ctrl_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // driver pins
  input wire logic pwm_pos_out,
  input wire logic pwm_neg_out,
  input wire logic rst_en_out,
  input wire logic fault_report_out_n,
  input wire logic supply_good_in
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----
  // helper counters
  // ----
  logic flt_prev_q, flt_prev_d;
  logic [9:0] since_q, since_d;
  logic [8:0] low_q, low_d;
  always_comb begin
    flt_prev_d = fault_report_out_n;
    since_d = (flt_prev_q && !fault_report_out_n) ? 10'h001 : since_q + {9'h000, since_q != 10'h3FF};
    low_d = rst_en_out ? 9'h000 : low_q + {8'h00, low_q != 9'h1FF};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_prev_q <= 1'b1;
      since_q <= 10'h000;
      low_q <= 9'h000;
    end else begin
      flt_prev_q <= flt_prev_d;
      since_q <= since_d;
      low_q <= low_d;
    end
  end
  // ----
  // assertions
  // ----
  AST_NEG_NEEDS_POS: assert property (pwm_neg_out |-> pwm_pos_out)
    else $error("inverting input high while non-inverting low");
  AST_OFF_AT_START: assert property ($rose(presetn) |-> !rst_en_out && !pwm_pos_out && !pwm_neg_out)
    else $error("driver pins not off after reset");
  AST_MUTE_KEPT: assert property ($fell(rst_en_out) && !fault_report_out_n |-> since_q >= 10'd400)
    else $error("clear pulse inside fault mute interval");
  AST_CLEAR_LEN: assert property ($rose(rst_en_out) && !fault_report_out_n |-> low_q == 9'd201)
    else $error("clear pulse length wrong");
  AST_ZERO_WAIT: assert property (psel && penable |-> pready)
    else $error("pready low in access");
  AST_ERR_UNMAPPED: assert property (psel && penable && paddr >= 12'h014 |-> pslverr)
    else $error("no error on unmapped address");
  AST_ERR_MAPPED: assert property (psel && penable && paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010}
    |-> !pslverr) else $error("error on mapped address");
  AST_ERR_IN_ACCESS: assert property (pslverr |-> psel && penable)
    else $error("error outside access");
  AST_RDATA_HOLD: assert property (psel && penable && !pwrite |=> $stable(prdata))
    else $error("read data changed after access");
endmodule : gdic_ctrl_chk

bind gdic_ctrl gdic_ctrl_chk gdic_ctrl_chk_inst (.*);

// ### sim/gdic_drv_model.sv
// behavioural gate driver input side: deglitch, interlock, fault latch and clear
// assumes pins sampled on pclk; outputs change by nba so readers see no race
`timescale 1ns/1ps
module gdic_drv_model #(parameter int MUTE_CYC = 400, parameter int FILT_CYC = 200) (
  // clock
  input wire logic pclk,
  // controller side
  input wire logic in_pos,
  input wire logic in_neg,
  input wire logic rst_en,
  // bench side
  input wire logic oc_trip,
  input wire logic supply_ok,
  output logic flt_oe_n = 1'b1,
  output logic rdy_oe_n = 1'b1,
  output logic gate = 1'b0
);
  logic [2:0] raw;
  logic [2:0] filt = 3'b000;
  logic prev, fault = 1'b0, armed = 1'b0;
  int cnt [3] = '{0, 0, 0};
  int mute = 0, lowc = 0;
  // an undriven reset/enable reads low, so the driver stays off
  assign raw = {rst_en === 1'b1, in_neg === 1'b1, in_pos === 1'b1};
  always @(posedge pclk) begin
    prev = filt[2];
    for (int i = 0; i < 3; i++) begin
      if (raw[i] == filt[i]) begin
        cnt[i] = 0;
      end else begin
        cnt[i] = cnt[i] + 1;
        if (cnt[i] == 8) filt[i] = raw[i];
      end
    end
    if (oc_trip) begin
      fault = 1'b1;
      armed = 1'b0;
      mute = MUTE_CYC;
    end else if (mute > 0) begin
      mute--;
      lowc = 0;
    end else if (fault) lowc = filt[2] ? 0 : lowc + 1;
    armed |= lowc > FILT_CYC;
    if (armed && filt[2] && !prev) begin
      fault = 1'b0;
      armed = 1'b0;
    end
    gate <= filt[0] & !filt[1] & filt[2] & !fault;
    flt_oe_n <= !fault;
    rdy_oe_n <= supply_ok;
  end
endmodule : gdic_drv_model

// ### sim/testbench.sv
// self-checking bench: apb tasks drive the controller, the driver model answers
// assumes zero-wait apb but waits on pready anyway
`timescale 1ns/1ps
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, oc_trip = 0, supply_ok = 1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, pos, neg, rst_en, flt_oe_n, rdy_oe_n, gate;
  wire flt_line = (flt_oe_n === 1'b0) ? 1'b0 : 1'b1;
  wire rdy_line = (rdy_oe_n === 1'b0) ? 1'b0 : 1'b1;
  int n_errors = 0, checked = 0, hi, n;
  logic [3:0] modes [4] = '{4'h9, 4'hB, 4'hD, 4'hF};
  always #2.5 pclk = ~pclk;
  gdic_ctrl gdic_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwm_pos_out(pos), .pwm_neg_out(neg), .rst_en_out(rst_en),
    .fault_report_out_n(flt_line), .supply_good_in(rdy_line));
  gdic_drv_model gdic_drv_model_inst (.pclk(pclk), .in_pos(pos), .in_neg(neg), .rst_en(rst_en),
    .oc_trip(oc_trip), .supply_ok(supply_ok), .flt_oe_n(flt_oe_n), .rdy_oe_n(rdy_oe_n), .gate(gate));
  task finish_test;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // entered just after a rising edge; leaves one idle cycle behind
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && k < 100) begin
      @(posedge pclk);
      k++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task count_gate;
    hi = 0;
    repeat (100) begin
      @(posedge pclk);
      hi += (gate === 1'b1);
    end
  endtask : count_gate
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(rst_en, 0);
    apb(0, 12'h000, 0); chk(rd, 0);
    apb(0, 12'h004, 0); chk(rd, 32'h0000_0FA0);
    apb(0, 12'h008, 0); chk(rd, 32'h0000_07D0);
    apb(0, 12'h014, 0); chk({rd[30:0], err}, 32'h0000_0001);
    apb(1, 12'h004, 32'h0000_0064);
    apb(1, 12'h008, 32'h0000_0028);
    // plain, auto reset, inverting, inverting with inverted auto reset
    for (int i = 0; i < 4; i++) begin
      apb(1, 12'h000, {28'h0, modes[i]});
      repeat (300) @(posedge pclk);
      count_gate(); chk(hi, 40);
    end
    // the last mode written must read back unchanged
    apb(0, 12'h000, 0); chk(rd, 32'h0000_000F);
    apb(1, 12'h000, 32'h0000_0008);
    repeat (50) @(posedge pclk);
    count_gate(); chk(hi, 0);
    chk(rst_en, 0);
    apb(1, 12'h000, 32'h0000_0009);
    repeat (300) @(posedge pclk);
    oc_trip <= 1'b1;
    @(posedge pclk);
    oc_trip <= 1'b0;
    repeat (5) @(posedge pclk);
    // a clear asked for inside the mute interval must wait for its end
    apb(1, 12'h00C, 32'h0000_0001);
    apb(0, 12'h010, 0); chk(rd[4:0], 5'h1F);
    count_gate(); chk(hi, 0);
    hi = 0;
    repeat (250) begin
      @(posedge pclk);
      hi += (rst_en !== 1'b1);
    end
    chk(hi, 0);
    n = 0;
    while (flt_line !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    chk(flt_line, 1);
    repeat (20) @(posedge pclk);
    apb(0, 12'h010, 0); chk(rd[4:0], 5'h06);
    apb(1, 12'h010, 32'h0000_0002);
    apb(0, 12'h010, 0); chk(rd[1], 0);
    count_gate(); chk(hi, 40);
    supply_ok <= 1'b0;
    repeat (5) @(posedge pclk);
    apb(0, 12'h010, 0); chk(rd[2], 0);
    finish_test();
  end
  initial begin
    #100000;
    n_errors++;
    finish_test();
  end
endmodule : testbench
